// ---- core/iat_pkg.sv ----
package iat_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int NS_PER_US       = 1000;
  localparam int US_CYC          = NS_PER_US / CLK_PERIOD_NS;
  localparam int START_DELAY_NS  = 23640;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TIME_NS     = 8760;
  localparam int FRAME_OVH_NS    = 511570;
  localparam int EXP_OVH_NS      = 30000;
  localparam logic [63:0] NS_PER_S = 64'h0000_0000_3B9A_CA00;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_EXPO   = 8'h04;
  localparam logic [7:0] OFS_HEIGHT = 8'h08;
  localparam logic [7:0] OFS_DEB    = 8'h0C;
  localparam logic [7:0] OFS_PAYLD  = 8'h10;
  localparam logic [7:0] OFS_THRU   = 8'h14;
  localparam logic [7:0] OFS_AVG    = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_RATE   = 8'h20;
  localparam logic [7:0] OFS_PERIOD = 8'h24;
  localparam logic [7:0] OFS_IRQ    = 8'h28;
  localparam logic [7:0] OFS_MASK   = 8'h2C;
  localparam int CTRL_ENA    = 0;
  localparam int CTRL_LEGACY = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CTRL_AVG    = 3;
  localparam int CTRL_DEB    = 4;
  localparam int CTRL_SEL_LO = 5;
  localparam int CTRL_SRC    = 7;
  localparam int IRQ_ACQ     = 0;
  localparam int IRQ_FRAME   = 1;
  localparam int IRQ_EXPEND  = 2;
  localparam logic [31:0] RST_EXPO   = 32'h0000_03E8;
  localparam logic [31:0] RST_HEIGHT = 32'h0000_01E0;
  localparam logic [31:0] RST_PAYLD  = 32'h0004_B000;
  localparam logic [31:0] RST_THRU   = 32'h0690_F380;
  localparam logic [7:0]  RST_AVG    = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAIT   = 3'b001,
    ST_DELAY  = 3'b010,
    ST_EXPOSE = 3'b011,
    ST_READ   = 3'b100,
    ST_TX     = 3'b101
  } iat_state_t;

  typedef enum logic [1:0] {
    RC_IDLE = 2'b00,
    RC_TX   = 2'b01,
    RC_FPS  = 2'b10
  } iat_rc_t;
endpackage

// ---- core/iat_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
module iat_tick #(
  parameter int DIV = 40
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic clr_i,
  output logic      tick_o
);
  initial if (DIV < 2) $error("DIV must be at least 2");
  logic [$clog2(DIV)-1:0] cnt;

  // restart on clear so the first tick falls a whole period after it
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else if (clr_i || cnt == $clog2(DIV)'(DIV - 1))
    begin
      cnt    <= '0;
      tick_o <= !clr_i;
    end
    else
    begin
      cnt    <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- core/iat_divu.sv ----
`timescale 1ns/10ps
`default_nettype none
module iat_divu #(
  parameter int W = 64
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // operands
  input  wire logic         start_i,
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  // result
  output logic              done_o,
  output logic [W-1:0]      quot_o
);
  initial if (W < 2) $error("W too small");
  logic [W-1:0]         rem;
  logic [W-1:0]         num;
  logic [W-1:0]         den;
  logic [$clog2(W):0]   cnt;
  logic                 busy;
  logic [W:0]           trial;

  assign trial = {rem, num[W-1]} - {1'b0, den};

  // restoring, one quotient bit a cycle; zero divisor gives all ones
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rem    <= '0;
      num    <= '0;
      den    <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
      quot_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        rem  <= '0;
        num  <= num_i;
        den  <= den_i;
        cnt  <= ($clog2(W)+1)'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem <= trial[W] ? {rem[W-2:0], num[W-1]} : trial[W-1:0];
        num <= {num[W-2:0], !trial[W]};
        cnt <= cnt - 1'b1;
        if (cnt == ($clog2(W)+1)'(1))
        begin
          busy   <= 1'b0;
          done_o <= 1'b1;
          quot_o <= {num[W-2:0], !trial[W]};
        end
      end
    end
endmodule
`default_nettype wire

// ---- core/iat_top.sv ----
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - trigger-wait status drives one of four lines
// - events on acq start, frame start, exposure end
// - trigger is frame start, legacy: acq start
// - exposure starts fixed delay after trigger edge
// - debounce time adds to start delay
// - readout into buffer follows exposure end
// - transmit once enough data is buffered
// - readout = (height+1)*row time + frame overhead
// - transmit = payload/throughput, at least readout
// - averaging sends one frame per group
// - readable resulting frame rate register
// - single frame mode need not reach max rate
// - readout-limited rate is reciprocal of readout
// - exposure-limited rate: exposure plus overhead
module iat_top
  import iat_pkg::*;
#(
  parameter int BUF_LEAD_NS = 2000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // trigger and lines
  input  wire logic        external_trigger_input_i,
  output logic [3:0]       line_o,
  // notifications and activity
  output logic             acq_start_notification_o,
  output logic             frame_start_notification_o,
  output logic             exposure_end_notification_o,
  output logic             exposing_o,
  output logic             readout_o,
  output logic             transmit_o,
  output logic             irq_o
);
  import iat_pkg::*;
  initial if (BUF_LEAD_NS < 0) $error("BUF_LEAD_NS negative");

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [31:0] expo_us, height, deb_us, payload, thru;
  logic [7:0]  avg_n;
  logic [2:0]  irq_stat, irq_mask;
  logic [31:0] rate_fps, period_ns;
  logic        dirty;
  logic        calc_busy;
  iat_state_t  state, next_state;
  logic        ena_q, trig_q, trig_rise;
  logic        acq_ev, frame_ev, exp_ev;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ctrl    <= 8'h00;
      expo_us <= RST_EXPO;
      height  <= RST_HEIGHT;
      deb_us  <= 32'h0000_0000;
      payload <= RST_PAYLD;
      thru    <= RST_THRU;
      avg_n   <= RST_AVG;
      irq_mask <= 3'h0;
    end
    else
    begin
      if (wr_i)
        unique case (addr_i)
          OFS_CTRL:   ctrl     <= wdata_i[7:0];
          OFS_EXPO:   expo_us  <= wdata_i;
          OFS_HEIGHT: height   <= {16'h0000, wdata_i[15:0]};
          OFS_DEB:    deb_us   <= wdata_i;
          OFS_PAYLD:  payload  <= wdata_i;
          OFS_THRU:   thru     <= wdata_i;
          OFS_AVG:    avg_n    <= (wdata_i[7:0] == 8'h00) ? 8'h01 : wdata_i[7:0];
          OFS_MASK:   irq_mask <= wdata_i[2:0];
          default:    ;
        endcase
      // single frame ends acquisition after one frame; no back-to-back rate
      if (ctrl[CTRL_SINGLE] && state == ST_TX && next_state == ST_WAIT)
        ctrl[CTRL_ENA] <= 1'b0;
    end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
      unique case (addr_i)
        OFS_CTRL:   rdata_o <= {24'h0, ctrl};
        OFS_EXPO:   rdata_o <= expo_us;
        OFS_HEIGHT: rdata_o <= height;
        OFS_DEB:    rdata_o <= deb_us;
        OFS_PAYLD:  rdata_o <= payload;
        OFS_THRU:   rdata_o <= thru;
        OFS_AVG:    rdata_o <= {24'h0, avg_n};
        OFS_STAT:   rdata_o <= {27'h0, dirty || calc_busy, 1'b0, state};
        OFS_RATE:   rdata_o <= rate_fps;
        OFS_PERIOD: rdata_o <= period_ns;
        OFS_IRQ:    rdata_o <= {29'h0, irq_stat};
        OFS_MASK:   rdata_o <= {29'h0, irq_mask};
        default:    rdata_o <= 32'h0000_0000;
      endcase

  // -----------------------------------------------------------------
  // interrupts: read clears, a new event in the same cycle survives
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      irq_stat <= 3'h0;
      irq_o    <= 1'b0;
    end
    else
    begin
      irq_stat <= ((rd_i && addr_i == OFS_IRQ) ? 3'h0 : irq_stat)
                | {exp_ev, frame_ev, acq_ev};
      irq_o    <= |(irq_stat & irq_mask);
    end

  // -----------------------------------------------------------------
  // frame rate limits
  // -----------------------------------------------------------------
  logic [31:0] readout_ns, expo_ns, txlim_ns, tx_ns;
  logic        cfg_wr;
  iat_rc_t     rc;
  logic        div_start, div_done;
  logic [63:0] div_num, div_den, div_q;
  logic [31:0] q_sat, next_period;

  assign calc_busy = rc != RC_IDLE;
  assign q_sat     = (div_q[63:32] != 32'h0) ? 32'hFFFF_FFFF : div_q[31:0];
  // slowest of the three limits sets the period; the rate divide needs it
  // in the same cycle, so it cannot come from the period register
  assign next_period = (readout_ns >= expo_ns && readout_ns >= q_sat) ? readout_ns
                     : (expo_ns >= q_sat) ? expo_ns : q_sat;

  assign readout_ns = 32'((height + 32'd1) * ROW_TIME_NS + FRAME_OVH_NS);
  assign expo_ns    = 32'(expo_us * NS_PER_US + EXP_OVH_NS);
  assign cfg_wr     = wr_i && addr_i <= OFS_AVG;

  iat_divu #(.W(64)) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .start_i(div_start),
    .num_i  (div_num),
    .den_i  (div_den),
    .done_o (div_done),
    .quot_o (div_q)
  );

  // averaging spreads one transmission over avg_n acquisitions
  always_comb
  begin
    div_num = (rc == RC_IDLE) ? 64'(payload) * NS_PER_S : NS_PER_S;
    div_den = (rc == RC_IDLE)
            ? 64'(thru) * 64'(ctrl[CTRL_AVG] ? avg_n : 8'h01)
            : 64'(next_period);
  end
  assign div_start = (rc == RC_IDLE && dirty) || (rc == RC_TX && div_done);

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rc        <= RC_IDLE;
      dirty     <= 1'b1;
      txlim_ns  <= 32'h0000_0000;
      period_ns <= 32'h0000_0001;
      rate_fps  <= 32'h0000_0000;
    end
    else
    begin
      // a write in the cycle the recompute starts keeps the flag set
      dirty <= cfg_wr || (dirty && rc != RC_IDLE);
      unique case (rc)
        RC_IDLE: if (dirty) rc <= RC_TX;
        RC_TX:
          if (div_done)
          begin
            txlim_ns  <= q_sat;
            rc        <= RC_FPS;
            period_ns <= next_period;
          end
        RC_FPS:
          if (div_done)
          begin
            rate_fps <= div_q[31:0];
            rc <= RC_IDLE;
          end
        default: rc <= RC_IDLE;
      endcase
    end

  // per-frame transmission time, never shorter than readout
  logic [31:0] txraw_ns;
  assign txraw_ns = 32'(64'(txlim_ns) * (ctrl[CTRL_AVG] ? avg_n : 8'h01));
  assign tx_ns    = (txraw_ns < readout_ns) ? readout_ns : txraw_ns;

  // -----------------------------------------------------------------
  // acquisition sequence
  // -----------------------------------------------------------------
  logic        us_tick, tick_clr;
  logic [31:0] cnt, rd_ns, tx_acc;
  logic        deb_phase, tx_run;
  logic [7:0]  avg_cnt;
  logic        last_frame;

  iat_tick #(.DIV(US_CYC)) u_tick (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (tick_clr),
    .tick_o(us_tick)
  );

  assign trig_rise  = external_trigger_input_i && !trig_q;
  assign last_frame = !ctrl[CTRL_AVG] || avg_cnt + 8'h01 >= avg_n;
  assign tick_clr   = state != next_state || (state == ST_DELAY && !deb_phase);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (ctrl[CTRL_ENA]) next_state = ST_WAIT;
      ST_WAIT:
        if (!ctrl[CTRL_ENA])
          next_state = ST_IDLE;
        else if (trig_rise)
          next_state = ST_DELAY;
      ST_DELAY:
        if (deb_phase ? (cnt >= deb_us)
                      : (cnt == 32'(START_DELAY_CYC - 1) && !ctrl[CTRL_DEB]))
          next_state = ST_EXPOSE;
      ST_EXPOSE: if (cnt >= expo_us) next_state = ST_READ;
      ST_READ:
        if (rd_ns + 32'(CLK_PERIOD_NS) >= readout_ns)
          next_state = tx_run ? ST_TX : ST_WAIT;
      ST_TX: if (!tx_run) next_state = ST_WAIT;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      state     <= ST_IDLE;
      cnt       <= 32'h0000_0000;
      deb_phase <= 1'b0;
      trig_q    <= 1'b0;
      ena_q     <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      trig_q <= external_trigger_input_i;
      ena_q  <= ctrl[CTRL_ENA];
      if (state != next_state)
      begin
        cnt       <= 32'h0000_0000;
        deb_phase <= 1'b0;
      end
      else if (state == ST_DELAY && !deb_phase)
      begin
        cnt <= cnt + 32'd1;
        if (cnt == 32'(START_DELAY_CYC - 1))
        begin
          deb_phase <= 1'b1;
          cnt       <= 32'h0000_0000;
        end
      end
      else if (us_tick)
        cnt <= cnt + 32'd1;
    end

  // readout fills the buffer; transmission drains it once a lead is held
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rd_ns   <= 32'h0000_0000;
      tx_acc  <= 32'h0000_0000;
      tx_run  <= 1'b0;
      avg_cnt <= 8'h00;
    end
    else
    begin
      rd_ns <= (state == ST_READ) ? rd_ns + 32'(CLK_PERIOD_NS) : 32'h0000_0000;
      if (state == ST_READ && !tx_run && last_frame && tx_acc == 32'h0
          && rd_ns >= 32'(BUF_LEAD_NS))
        tx_run <= 1'b1;
      else if (tx_run && tx_acc + 32'(CLK_PERIOD_NS) >= tx_ns)
        tx_run <= 1'b0;
      if (tx_run)
        tx_acc <= tx_acc + 32'(CLK_PERIOD_NS);
      else if (state != ST_READ)
        tx_acc <= 32'h0000_0000;
      if (state == ST_READ && next_state != ST_READ)
        avg_cnt <= last_frame ? 8'h00 : avg_cnt + 8'h01;
    end

  // -----------------------------------------------------------------
  // events and pins
  // -----------------------------------------------------------------
  logic wait_st;
  assign wait_st  = state == ST_WAIT;
  assign frame_ev = wait_st && next_state == ST_DELAY;
  assign acq_ev   = ctrl[CTRL_LEGACY] ? frame_ev
                  : (ctrl[CTRL_ENA] && !ena_q);
  assign exp_ev   = state == ST_EXPOSE && next_state == ST_READ;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      acq_start_notification_o    <= 1'b0;
      frame_start_notification_o  <= 1'b0;
      exposure_end_notification_o <= 1'b0;
      exposing_o <= 1'b0;
      readout_o  <= 1'b0;
      transmit_o <= 1'b0;
      line_o     <= 4'h0;
    end
    else
    begin
      acq_start_notification_o    <= acq_ev;
      frame_start_notification_o  <= frame_ev;
      exposure_end_notification_o <= exp_ev;
      exposing_o <= next_state == ST_EXPOSE;
      readout_o  <= next_state == ST_READ;
      transmit_o <= tx_run;
      line_o     <= (ctrl[CTRL_SRC] && wait_st)
                  ? 4'(4'h1 << ctrl[CTRL_SEL_LO +: 2]) : 4'h0;
    end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic [31:0] dly_cyc;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      dly_cyc <= 32'h0;
    else
      dly_cyc <= (state == ST_DELAY) ? dly_cyc + 32'd1 : 32'h0;

  property p_line;
    @(posedge clk_i) disable iff (rst_i)
    (wait_st && ctrl[CTRL_SRC]) |=> line_o == 4'(4'h1 << $past(ctrl[CTRL_SEL_LO +: 2]));
  endproperty
  a_line: assert property (p_line) else $error("wait status not on line");
  property p_expend;
    @(posedge clk_i) disable iff (rst_i)
    exp_ev |=> exposure_end_notification_o && readout_o;
  endproperty
  a_expend: assert property (p_expend) else $error("exposure end lost");
  property p_std;
    @(posedge clk_i) disable iff (rst_i)
    (frame_ev && !ctrl[CTRL_LEGACY] && ena_q) |=> frame_start_notification_o
      && !acq_start_notification_o;
  endproperty
  a_std: assert property (p_std) else $error("standard mode event wrong");
  property p_delay;
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_DELAY && next_state == ST_EXPOSE) |-> dly_cyc >= START_DELAY_CYC - 1;
  endproperty
  a_delay: assert property (p_delay) else $error("exposure started early");
  property p_deb;
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_DELAY && next_state == ST_EXPOSE && ctrl[CTRL_DEB])
      |-> dly_cyc >= START_DELAY_CYC + deb_us * US_CYC - 1;
  endproperty
  a_deb: assert property (p_deb) else $error("debounce time not added");
  property p_read;
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_EXPOSE && next_state != ST_EXPOSE) |=> state == ST_READ ##1 readout_o;
  endproperty
  a_read: assert property (p_read) else $error("readout did not follow");
  property p_txlead;
    @(posedge clk_i) disable iff (rst_i)
    $rose(tx_run) |-> $past(rd_ns) >= BUF_LEAD_NS;
  endproperty
  a_txlead: assert property (p_txlead) else $error("transmit before lead");
  property p_txmin;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> tx_ns >= readout_ns;
  endproperty
  a_txmin: assert property (p_txmin) else $error("transmit shorter than readout");
  property p_avg;
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_READ && !last_frame) |=> !$rose(tx_run);
  endproperty
  a_avg: assert property (p_avg) else $error("averaged frame sent early");
  property p_min;
    @(posedge clk_i) disable iff (rst_i)
    (rc == RC_FPS && !cfg_wr && !$past(cfg_wr)) |-> period_ns >= readout_ns
      && period_ns >= expo_ns;
  endproperty
  a_min: assert property (p_min) else $error("period below a limit");

  c_frame: cover property (@(posedge clk_i) disable iff (rst_i) frame_ev ##[1:1000] exp_ev);
  c_tx:    cover property (@(posedge clk_i) disable iff (rst_i) state == ST_TX);
  c_rate:  cover property (@(posedge clk_i) disable iff (rst_i) rc == RC_FPS && div_done);
endmodule
`default_nettype wire

// ---- tb/iat_far.sv ----
`timescale 1ns/10ps
`default_nettype none
module iat_far (
  // clock
  input  wire logic clk_i,
  // trigger source
  input  wire logic fire_i,
  output logic      trig_o,
  // host receiver
  input  wire logic transmit_i,
  output int        n_tx_o
);
  logic [1:0] hold = 2'h0;
  logic       tx_q = 1'b0;

  // ----------------------------------------
  // trigger: three cycles high, then idle low
  // ----------------------------------------
  assign trig_o = |hold;
  always @(posedge clk_i)
  begin
    if (fire_i)
      hold <= 2'h3;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
  end

  // ----------------------------------------
  // host: a new burst restarts the count
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    tx_q <= transmit_i;
    if (transmit_i && !tx_q)
      n_tx_o <= 1;
    else if (transmit_i)
      n_tx_o <= n_tx_o + 1;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import iat_pkg::*;
  localparam int LEAD_NS = 100;
  localparam int LEAD = LEAD_NS / CLK_PERIOD_NS;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  addr_i  = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        fire    = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0]  line_o;
  logic        acq_o, fs_o, ee_o, xp_o, ro_o, tx_o, irq_o, trig;
  int          n_tx, n_errors = 0, comparisons = 0, cyc = 0;
  int          n_fs = 0, n_acq = 0, n_te = 0;
  int          t_trig, t_fs, t_acq, t_ee, t_xr, t_xf, t_rr, t_rf, t_tr, t_ir;
  logic [4:0]  p = 5'h00;

  always #12.5 clk_i = ~clk_i;

  iat_top #(
    .BUF_LEAD_NS (LEAD_NS)
  ) dut_u (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .addr_i                      (addr_i),
    .wdata_i                     (wdata_i),
    .wr_i                        (wr_i),
    .rd_i                        (rd_i),
    .rdata_o                     (rdata_o),
    .external_trigger_input_i    (trig),
    .line_o                      (line_o),
    .acq_start_notification_o    (acq_o),
    .frame_start_notification_o  (fs_o),
    .exposure_end_notification_o (ee_o),
    .exposing_o                  (xp_o),
    .readout_o                   (ro_o),
    .transmit_o                  (tx_o),
    .irq_o                       (irq_o)
  );

  iat_far far_u (
    .clk_i      (clk_i),
    .fire_i     (fire),
    .trig_o     (trig),
    .transmit_i (tx_o),
    .n_tx_o     (n_tx)
  );

  // ----------------------------------------
  // monitor: cycle stamps of pulses and rising edges, plus exposure and readout falls
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    cyc++;
    n_fs += int'(fs_o);
    n_acq += int'(acq_o);
    if (trig && !p[0]) t_trig = cyc;
    if (fs_o) t_fs = cyc;
    if (acq_o) t_acq = cyc;
    if (ee_o) t_ee = cyc;
    if (xp_o && !p[1]) t_xr = cyc;
    if (!xp_o && p[1]) t_xf = cyc;
    if (ro_o && !p[2]) t_rr = cyc;
    if (!ro_o && p[2]) t_rf = cyc;
    if (tx_o && !p[3]) t_tr = cyc;
    if (!tx_o && p[3]) n_te++;
    if (irq_o && !p[4]) t_ir = cyc;
    p = {irq_o, tx_o, ro_o, xp_o, trig};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // the recompute takes a while; poll the dirty-or-busy status bit under a bound
  task automatic wait_calc;
    logic [31:0] s;
    int          i;
    repeat (4) @(posedge clk_i);
    s = 32'h0000_0010;
    for (i = 0; i < 200 && s[4] !== 1'b0; i++) rd(OFS_STAT, s);
    chk({31'h0, s[4]}, 32'h0);
  endtask

  task automatic fire_trig;
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
  endtask

  function automatic logic [63:0] period(input longint h, e, pl, av);
    longint ro, ex, tx, m;
    ro = (h + 1) * ROW_TIME_NS + FRAME_OVH_NS;
    ex = e * NS_PER_US + EXP_OVH_NS;
    tx = pl * NS_PER_S / (RST_THRU * av);
    m = (ro > ex) ? ro : ex;
    return (m > tx) ? m : tx;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [63:0] pr, q;
    wait_calc;
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_EXPO, RST_EXPO);
    rchk(OFS_HEIGHT, RST_HEIGHT);
    rchk(OFS_PAYLD, RST_PAYLD);
    rchk(OFS_THRU, RST_THRU);
    rchk(OFS_AVG, {24'h0, RST_AVG});
    rchk(OFS_MASK, 32'h0);
    rchk(8'h30, 32'h0);
    pr = period(RST_HEIGHT, RST_EXPO, RST_PAYLD, 1);
    q = NS_PER_S / pr;
    wr(OFS_RATE, 32'h55);
    rchk(OFS_PERIOD, pr[31:0]);
    rchk(OFS_RATE, q[31:0]);
    wr(OFS_AVG, 32'h0);
    rchk(OFS_AVG, 32'h1);
  endtask

  task automatic rate_case(input logic [31:0] h, e, pl, c, av);
    logic [63:0] pr, q;
    wr(OFS_HEIGHT, h);
    wr(OFS_EXPO, e);
    wr(OFS_PAYLD, pl);
    wr(OFS_AVG, av);
    wr(OFS_CTRL, c);
    wait_calc;
    pr = period(h, e, pl, c[CTRL_AVG] ? av : 1);
    q = NS_PER_S / pr;
    rchk(OFS_PERIOD, pr[31:0]);
    rchk(OFS_RATE, q[31:0]);
  endtask

  task automatic t_frame;
    int i, k, fs0, t1, rdc;
    rdc = (2 * ROW_TIME_NS + FRAME_OVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    wr(OFS_HEIGHT, 32'h1);
    wr(OFS_EXPO, 32'h2);
    wr(OFS_PAYLD, 32'h3E8);
    wr(OFS_AVG, 32'h1);
    wr(OFS_MASK, 32'h1);
    k = n_acq;
    wr(OFS_CTRL, 32'hC1);
    wait_calc;
    chk({28'h0, line_o}, 32'h4);
    chk(n_acq - k, 1);
    chk({31'h0, irq_o}, 32'h1);
    rchk(OFS_IRQ, 32'h1);
    wr(OFS_MASK, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    fs0 = n_fs;
    fire_trig;
    repeat (300) @(posedge clk_i);
    t1 = t_trig;
    chk({28'h0, line_o}, 32'h0);
    // a second trigger in mid-frame must be ignored
    fire_trig;
    k = n_te;
    for (i = 0; i < 45000 && n_te == k; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    chk(n_fs - fs0, 1);
    chk_rng(t_fs - t1, 1, 1);
    chk_rng(t_xr - t1, START_DELAY_CYC, START_DELAY_CYC + 3);
    chk_rng(t_xf - t_xr, 2 * US_CYC, 2 * US_CYC + 2);
    chk_rng(t_ee - t_xf, -1, 1);
    chk_rng(t_rr - t_ee, -1, 1);
    chk_rng(t_rf - t_rr, rdc - 1, rdc + 1);
    chk_rng(t_tr - t_rr, LEAD + 1, LEAD + 4);
    chk_rng(n_tx, rdc - 1, rdc + 1);
    // frame bit is masked, so irq waits for exposure end
    chk_rng(t_ir - t_ee, 0, 2);
    chk({28'h0, line_o}, 32'h4);
    rchk(OFS_IRQ, 32'h6);
    rchk(OFS_STAT, 32'h1);
  endtask

  task automatic t_legacy;
    int i, a0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(OFS_DEB, 32'h5);
    wr(OFS_CTRL, 32'h13);
    wait_calc;
    a0 = n_acq;
    fire_trig;
    for (i = 0; i < 1500 && xp_o !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk(n_acq - a0, 1);
    chk_rng(t_acq - t_trig, 1, 1);
    chk_rng(t_fs - t_trig, 1, 1);
    chk_rng(t_xr - t_trig, START_DELAY_CYC + 5 * US_CYC, START_DELAY_CYC + 5 * US_CYC + 4);
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    print_verdict;
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    rate_case(32'h190, 32'h7D0, 32'h3A980, 32'h0, 32'h1);
    rate_case(32'h190, 32'h1388, 32'h3A980, 32'h0, 32'h1);
    rate_case(32'h190, 32'h7D0, 32'h10C8E0, 32'h0, 32'h1);
    rate_case(32'h190, 32'h7D0, 32'h10C8E0, 32'h8, 32'h4);
    t_frame;
    t_legacy;
    print_verdict;
  end
endmodule
`default_nettype wire
